// ### ccs_host.sv
/*
  ccs_host: remote controller model, one command at a time.
  assumes the unit takes a command at a rising edge with ready high.
*/
`timescale 1ns/100ps
`default_nettype none
module ccs_host (
  input wire logic clk_i,
  input wire logic ready_i,
  output var logic valid_o,
  output var ccs_pkg::ccs_req_s req_o
);
  initial begin
    valid_o = 1'b0;
    req_o = '0;
  end
  // slot, weight, no wait after sequential
  task automatic send(input ccs_pkg::ccs_cmd_e c, input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_i);
    valid_o <= 1'b1;
    req_o <= '{cmd: c, arg: a};
    // ready is a register, so it is steady from negedge to edge
    @(negedge clk_i);
    while (ready_i !== 1'b1 && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    // released lines show the inverse, never the stale command
    req_o <= ccs_pkg::ccs_req_s'(~{c, a});
  endtask
endmodule
`default_nettype wire

// ### ccs_pkg.sv
/*
  ccs_pkg: shared types and constants for the common command and status unit.
  assumes a single 100 MHz instrument clock and a decoded command stream.
*/
package ccs_pkg;

  // command opcodes as delivered by the upstream parser
  typedef enum logic [3:0] {
    CMD_NONE     = 4'h0,
    CMD_SAVE     = 4'h1,  // save settings to slot
    CMD_SRE_WR   = 4'h2,  // write service request enable
    CMD_SRE_RD   = 4'h3,  // query service request enable
    CMD_STB_RD   = 4'h4,  // query status byte
    CMD_TRIG     = 4'h5,  // bus trigger
    CMD_SELFTEST = 4'h6,  // self-test query
    CMD_WAIT     = 4'h7,  // wait for overlapped ops
    CMD_START    = 4'h8,  // start_trigger_model_cmd
    CMD_CALSTEP  = 4'h9,  // calibration_step_data_cmd, step 1..8
    CMD_DEFRST   = 4'hA,  // default reset
    CMD_OTHER    = 4'hB   // any other sequential command
  } ccs_cmd_e;

  // arm layer control sources
  typedef enum logic [1:0] {
    ARM_IMM = 2'h0,
    ARM_BUS = 2'h1,
    ARM_EXT = 2'h2
  } ccs_arm_e;

  localparam int SET_W = 32;         // width of the setup word
  localparam int SLOT_N = 5;         // number of setup slots
  localparam logic [2:0] SLOT_MIN = 3'h1;
  localparam logic [2:0] SLOT_MAX = 3'h5;
  localparam logic [3:0] CAL_MIN = 4'h1;
  localparam logic [3:0] CAL_MAX = 4'h8;
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic [7:0] SRE_CLR = 8'h00;
  localparam logic [7:0] SRE_RQS = 8'h20;  // weight 32 enables request
  localparam logic [7:0] SELFTEST_ANS = 8'h00;
  localparam logic [SET_W-1:0] SET_DEFAULT = 32'h0000_0000;

  // one incoming command
  typedef struct packed {
    ccs_cmd_e cmd;
    logic [7:0] arg;
  } ccs_req_s;

  // one reply
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ccs_rsp_s;

endpackage

// ### ccs_props.sv
/*
  ccs_props: port assertions for ccs_top, attached by bind.
  assumes one clock and the sync active-high reset of ccs_top.
*/
`timescale 1ns/100ps
`default_nettype none
module ccs_props (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic CMD_VALID_I,
  input wire ccs_pkg::ccs_req_s CMD_I,
  input wire logic CMD_READY_O,
  input wire ccs_pkg::ccs_rsp_s RSP_O,
  input wire logic [7:0] STATUS_BYTE_I,
  input wire ccs_pkg::ccs_arm_e ARM_SRC_I,
  input wire logic OP_BUSY_I,
  input wire logic SEQ_DONE_I,
  input wire logic [ccs_pkg::SET_W-1:0] SETTINGS_O,
  input wire logic [7:0] SRE_O,
  input wire logic BUS_TRIG_O,
  input wire logic START_O,
  input wire logic CANCEL_O,
  input wire logic SLOT_ERR_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  logic [15:0] tk; // one-hot opcode taken this edge
  logic wt_q; // wait pending
  logic sq_q; // sequential work pending
  assign tk = (CMD_VALID_I && CMD_READY_O) ? 16'h0001 << CMD_I.cmd : 16'h0000;
  // pending flags drop when the awaited event is seen
  always_ff @(posedge CLK_SYS_I) begin
    wt_q <= !SRST_I && (tk[ccs_pkg::CMD_WAIT] || (wt_q && OP_BUSY_I));
    sq_q <= !SRST_I && (tk[ccs_pkg::CMD_OTHER] || (sq_q && !SEQ_DONE_I));
  end
  AST_SRE_RD: assert property (tk[ccs_pkg::CMD_SRE_RD] |=>
    RSP_O.valid && RSP_O.data == SRE_O) else $error("enable reply wrong");
  AST_STB: assert property (tk[ccs_pkg::CMD_STB_RD] |=>
    RSP_O.valid && RSP_O.data == $past(STATUS_BYTE_I)) else $error("status reply wrong");
  AST_TST: assert property (tk[ccs_pkg::CMD_SELFTEST] |=>
    RSP_O.valid && RSP_O.data == 8'h00) else $error("self-test reply wrong");
  AST_SRE_WR: assert property (tk[ccs_pkg::CMD_SRE_WR] |=>
    SRE_O == $past(CMD_I.arg)) else $error("enable write wrong");
  AST_TRIG: assert property (tk[ccs_pkg::CMD_TRIG] |=>
    BUS_TRIG_O == ($past(ARM_SRC_I) == ccs_pkg::ARM_BUS) ##1 CMD_READY_O)
    else $error("trigger wrong");
  AST_START: assert property (tk[ccs_pkg::CMD_START] |=> START_O ##1 CMD_READY_O)
    else $error("start pulse wrong");
  AST_WAIT: assert property (wt_q && OP_BUSY_I |=> !CMD_READY_O)
    else $error("wait released early");
  AST_SEQ: assert property (sq_q && !SEQ_DONE_I |=> !CMD_READY_O)
    else $error("sequential released early");
  AST_SLOT: assert property (tk[ccs_pkg::CMD_SAVE] |=> SLOT_ERR_O ==
    ($past(CMD_I.arg) == 8'h00 || $past(CMD_I.arg) > 8'h05)) else $error("slot check wrong");
  AST_DEFRST: assert property (tk[ccs_pkg::CMD_DEFRST] |=> CANCEL_O &&
    SETTINGS_O == 32'h0000_0000 && $stable(SRE_O)) else $error("default reset wrong");
  cover property (tk[ccs_pkg::CMD_WAIT] && OP_BUSY_I);
  cover property (BUS_TRIG_O);
  cover property (SLOT_ERR_O);
endmodule
bind ccs_top ccs_props u_props (.*);
`default_nettype wire

// ### ccs_slot_mem.sv
/*
  ccs_slot_mem: five setup slots of settings words.
  assumes the caller checks the slot range before writing.
*/
`timescale 1ns/100ps
`default_nettype none
module ccs_slot_mem (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [2:0] slot_i,
  input wire logic [ccs_pkg::SET_W-1:0] data_i,
  output logic [ccs_pkg::SET_W-1:0] rd_o
);
  // slot array, index 0 holds slot 1; contents undefined until saved
  logic [ccs_pkg::SET_W-1:0] mem_q [ccs_pkg::SLOT_N];
  logic [2:0] idx;

  // slot number to array index
  always_comb begin
    idx = slot_i - ccs_pkg::SLOT_MIN;
  end

  // a later save simply overwrites the slot
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem_q[idx] <= data_i;
    end
  end

  // read port, left unconnected in ccs_top, so no recall logic reads it
  always_comb begin
    rd_o = mem_q[idx];
  end
endmodule
`default_nettype wire

// ### ccs_top.sv
/*
  ccs_top: common command and status unit. takes decoded commands one at a
  time, answers queries, keeps the service request enable, fires bus
  triggers and stalls on the wait command.
  assumes commands are synchronous to CLK_SYS_I and a command is held until
  CMD_READY_O is seen high with CMD_VALID_I.
*/
// How it works
// - saving overwrites the slot silently
// - saved word holds every default-reset setting
// - writing 0 clears the enable register
// - writing 32 enables service request
// - enable query returns weighted bit sum
// - trigger command acts as bus trigger
// - trigger honoured only with bus arm source
// - self-test query answers 0 at once
// - overlapped commands let later ones start
// - sequential commands finish before next starts
// - wait stalls until overlapped work finished
// - only trigger, start, cal steps overlap
// - default reset restores, cancels pending work
`timescale 1ns/100ps
`default_nettype none
module ccs_top (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic CMD_VALID_I,
  input wire ccs_pkg::ccs_req_s CMD_I,
  output logic CMD_READY_O,
  output ccs_pkg::ccs_rsp_s RSP_O,
  input wire logic [ccs_pkg::SET_W-1:0] SETTINGS_I,
  input wire logic [7:0] STATUS_BYTE_I,
  input wire ccs_pkg::ccs_arm_e ARM_SRC_I,
  input wire logic OP_BUSY_I,
  input wire logic SEQ_DONE_I,
  output logic [ccs_pkg::SET_W-1:0] SETTINGS_O,
  output logic SETTINGS_LOAD_O,
  output logic [7:0] SRE_O,
  output logic BUS_TRIG_O,
  output logic START_O,
  output logic [3:0] CAL_STEP_O,
  output logic CAL_STEP_STB_O,
  output logic SEQ_START_O,
  output logic CANCEL_O,
  output logic SLOT_ERR_O
);
  // command sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,  // ready for a command
    ST_SEQ = 4'b0010,   // sequential command in progress
    ST_WAIT = 4'b0100,  // holding for overlapped work
    ST_SETTLE = 4'b1000 // one cycle for busy to rise
  } ccs_st_e;

  ccs_st_e st_q, st_d;
  logic ready_q, ready_d;              // command accept
  ccs_pkg::ccs_rsp_s rsp_q, rsp_d;     // reply register
  logic [7:0] sre_q, sre_d;            // service request enable
  logic trig_q, trig_d;                // bus trigger pulse
  logic start_q, start_d;              // start pulse
  logic [3:0] cal_q, cal_d;            // calibration step number
  logic cal_stb_q, cal_stb_d;          // calibration step pulse
  logic seq_q, seq_d;                  // sequential start pulse
  logic cancel_q, cancel_d;            // cancel pulse
  logic load_q, load_d;                // load defaults pulse
  logic [ccs_pkg::SET_W-1:0] set_q, set_d; // settings to apply
  logic slot_err_q, slot_err_d;        // bad slot pulse
  logic save_wr;                       // slot write strobe
  logic take;                          // command accepted this cycle
  logic slot_ok;                       // slot number in range

  // slot storage; the recall path is outside this unit
  ccs_slot_mem u_slots (
    .clk_i(CLK_SYS_I),
    .wr_i(save_wr),
    .slot_i(CMD_I.arg[2:0]),
    .data_i(SETTINGS_I),
    .rd_o()
  );

  // command accept and slot range check
  always_comb begin
    take = CMD_VALID_I && ready_q;
    slot_ok = (CMD_I.arg >= {5'h00, ccs_pkg::SLOT_MIN}) &&
              (CMD_I.arg <= {5'h00, ccs_pkg::SLOT_MAX});
    save_wr = take && (CMD_I.cmd == ccs_pkg::CMD_SAVE) && slot_ok;
  end

  // next-state logic of the sequencer and registers
  always_comb begin
    st_d = st_q;
    ready_d = ready_q;
    rsp_d = '{valid: 1'b0, data: 8'h00};
    sre_d = sre_q;
    trig_d = 1'b0;
    start_d = 1'b0;
    cal_d = cal_q;
    cal_stb_d = 1'b0;
    seq_d = 1'b0;
    cancel_d = 1'b0;
    load_d = 1'b0;
    set_d = set_q;
    slot_err_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (take) begin
          ready_d = 1'b0;
          st_d = ST_SETTLE;
          case (CMD_I.cmd)
            ccs_pkg::CMD_SAVE: begin
              slot_err_d = !slot_ok;
            end
            ccs_pkg::CMD_SRE_WR: begin
              sre_d = CMD_I.arg;
            end
            ccs_pkg::CMD_SRE_RD: begin
              rsp_d = '{valid: 1'b1, data: sre_q};
            end
            ccs_pkg::CMD_STB_RD: begin
              rsp_d = '{valid: 1'b1, data: STATUS_BYTE_I};
            end
            ccs_pkg::CMD_TRIG: begin
              trig_d = (ARM_SRC_I == ccs_pkg::ARM_BUS);
            end
            ccs_pkg::CMD_START: begin
              start_d = 1'b1;
            end
            ccs_pkg::CMD_CALSTEP: begin
              // overlapped only for steps 1 to 8
              if (CMD_I.arg[3:0] >= ccs_pkg::CAL_MIN &&
                  CMD_I.arg[3:0] <= ccs_pkg::CAL_MAX && CMD_I.arg[7:4] == 4'h0) begin
                cal_d = CMD_I.arg[3:0];
                cal_stb_d = 1'b1;
              end
            end
            ccs_pkg::CMD_SELFTEST: begin
              rsp_d = '{valid: 1'b1, data: ccs_pkg::SELFTEST_ANS};
            end
            ccs_pkg::CMD_WAIT: begin
              st_d = ST_WAIT;
            end
            ccs_pkg::CMD_DEFRST: begin
              set_d = ccs_pkg::SET_DEFAULT;
              load_d = 1'b1;
              cancel_d = 1'b1;
            end
            ccs_pkg::CMD_OTHER: begin
              seq_d = 1'b1;
              st_d = ST_SEQ;
            end
            default: begin
              st_d = ST_SETTLE;
            end
          endcase
        end
      end
      ST_SEQ: begin
        if (SEQ_DONE_I) begin
          st_d = ST_IDLE;
          ready_d = 1'b1;
        end
      end
      ST_WAIT: begin
        // settle cycle lets a just-issued overlap raise busy first
        if (!OP_BUSY_I && !trig_q && !start_q && !cal_stb_q) begin
          st_d = ST_IDLE;
          ready_d = 1'b1;
        end
      end
      ST_SETTLE: begin
        // overlapped work does not hold us
        st_d = ST_IDLE;
        ready_d = 1'b1;
      end
      default: begin
        st_d = ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // register stage; enable cleared at reset or by writing 0
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      st_q <= ST_IDLE;
      ready_q <= 1'b1;
      rsp_q <= '{valid: 1'b0, data: 8'h00};
      sre_q <= ccs_pkg::SRE_RST;
      trig_q <= 1'b0;
      start_q <= 1'b0;
      cal_q <= 4'h0;
      cal_stb_q <= 1'b0;
      seq_q <= 1'b0;
      cancel_q <= 1'b0;
      load_q <= 1'b0;
      set_q <= ccs_pkg::SET_DEFAULT;
      slot_err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ready_q <= ready_d;
      rsp_q <= rsp_d;
      sre_q <= sre_d;
      trig_q <= trig_d;
      start_q <= start_d;
      cal_q <= cal_d;
      cal_stb_q <= cal_stb_d;
      seq_q <= seq_d;
      cancel_q <= cancel_d;
      load_q <= load_d;
      set_q <= set_d;
      slot_err_q <= slot_err_d;
    end
  end

  // outputs straight from flops
  assign CMD_READY_O = ready_q;
  assign RSP_O = rsp_q;
  assign SRE_O = sre_q;
  assign BUS_TRIG_O = trig_q;
  assign START_O = start_q;
  assign CAL_STEP_O = cal_q;
  assign CAL_STEP_STB_O = cal_stb_q;
  assign SEQ_START_O = seq_q;
  assign CANCEL_O = cancel_q;
  assign SETTINGS_LOAD_O = load_q;
  assign SETTINGS_O = set_q;
  assign SLOT_ERR_O = slot_err_q;
endmodule
`default_nettype wire

// ### common_command_status_unit_test.sv
/*
  common_command_status_unit_test: self-checking bench for ccs_top.
  assumes ccs_host issues commands; replies are checked from a queue.
*/
`timescale 1ns/100ps
`default_nettype none
module common_command_status_unit_test;
  logic clk = 1'b0, rst = 1'b1, busy = 1'b0, done = 1'b0;
  logic vld, rdy, trig, strt, serr;
  logic ld, cstb, sqs, cnl; // load, cal strobe, sequential start and cancel pulses
  logic [7:0] stb = 8'h00, sre, r;
  logic [3:0] cs;
  logic [31:0] set = 32'h0000_0000, so;
  ccs_pkg::ccs_arm_e arm = ccs_pkg::ARM_IMM;
  ccs_pkg::ccs_req_s req;
  ccs_pkg::ccs_rsp_s rsp;
  logic [7:0] exp_q[$]; // expected replies, oldest first
  int mismatches = 0, n_tests = 0, n_trig = 0, n_err = 0, n_st = 0;
  int n_ld = 0, n_cs = 0, n_sq = 0, n_cn = 0; // pulse counts, one per output pulse
  realtime t_ev = 1e9; // far future until the awaited event happens
  always #5 clk = ~clk;
  ccs_top uut (.CLK_SYS_I(clk), .SRST_I(rst), .CMD_VALID_I(vld), .CMD_I(req),
    .CMD_READY_O(rdy), .RSP_O(rsp), .SETTINGS_I(set), .STATUS_BYTE_I(stb),
    .ARM_SRC_I(arm), .OP_BUSY_I(busy), .SEQ_DONE_I(done), .SETTINGS_O(so),
    .SETTINGS_LOAD_O(ld), .SRE_O(sre), .BUS_TRIG_O(trig), .START_O(strt),
    .CAL_STEP_O(cs), .CAL_STEP_STB_O(cstb), .SEQ_START_O(sqs), .CANCEL_O(cnl),
    .SLOT_ERR_O(serr));
  ccs_host host (.clk_i(clk), .ready_i(rdy), .valid_o(vld), .req_o(req));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic ask(input ccs_pkg::ccs_cmd_e c, input logic [7:0] e);
    exp_q.push_back(e);
    host.send(c, 8'h00);
  endtask
  // three negedges: pulse seen and counted by the monitor
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // pulse counts and replies against the oldest note
  always @(posedge clk) begin
    n_trig += trig;
    n_err += serr;
    n_st += strt;
    n_ld += ld;
    n_cs += cstb;
    n_sq += sqs;
    n_cn += cnl;
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) check("reply count", 32'h1, 32'h0);
      else check("reply", rsp.data, exp_q.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h9088));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("sre", sre, 8'h00);
    check("ready", rdy, 1'b1);
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 8'h20 : (i == 1) ? 8'h00 : 8'($urandom);
      host.send(ccs_pkg::CMD_SRE_WR, r);
      ask(ccs_pkg::CMD_SRE_RD, r);
    end
    host.send(ccs_pkg::CMD_DEFRST, 8'h00);
    settle();
    check("settings", so, 32'h0000_0000);
    check("sre kept", sre, r);
    check("load pulses", n_ld, 1);
    check("cancel pulses", n_cn, 1);
    $display("enable and default reset test done");
    @(posedge clk);
    set <= $urandom;
    for (int i = 0; i < 8; i++) host.send(ccs_pkg::CMD_SAVE, 8'(i));
    settle();
    check("slot errors", n_err, 3);
    check("slot 1", uut.u_slots.mem_q[0], set);
    @(posedge clk);
    set <= ~set;
    host.send(ccs_pkg::CMD_SAVE, 8'h05);
    settle();
    check("slot 5 new", uut.u_slots.mem_q[4], set);
    check("slot 1 kept", uut.u_slots.mem_q[0], ~set);
    @(posedge clk);
    r = 8'($urandom);
    stb <= r;
    ask(ccs_pkg::CMD_STB_RD, r);
    ask(ccs_pkg::CMD_STB_RD, r);
    ask(ccs_pkg::CMD_SELFTEST, 8'h00);
    $display("save and query test done");
    for (int a = 0; a < 3; a++) begin
      arm <= ccs_pkg::ccs_arm_e'(a);
      busy <= 1'b1;
      host.send(ccs_pkg::CMD_TRIG, 8'h00);
    end
    ask(ccs_pkg::CMD_SELFTEST, 8'h00);
    settle();
    check("bus triggers", n_trig, 1);
    host.send(ccs_pkg::CMD_WAIT, 8'h00);
    fork
      begin
        repeat (12) @(posedge clk);
        busy <= 1'b0;
        t_ev = $time;
      end
    join_none
    ask(ccs_pkg::CMD_SELFTEST, 8'h00);
    check("wait held", $time > t_ev, 1'b1);
    t_ev = 1e9;
    host.send(ccs_pkg::CMD_OTHER, 8'h00);
    fork
      begin
        repeat (6) @(posedge clk);
        done <= 1'b1;
        t_ev = $time;
        @(posedge clk);
        done <= 1'b0;
      end
    join_none
    ask(ccs_pkg::CMD_SELFTEST, 8'h00);
    check("sequential held", $time > t_ev, 1'b1);
    check("seq starts", n_sq, 1);
    $display("trigger, wait and sequential test done");
    host.send(ccs_pkg::CMD_START, 8'h00);
    for (int s = 0; s < 10; s++) begin
      host.send(ccs_pkg::CMD_CALSTEP, 8'(s));
      settle();
      check("cal step", cs, (s == 0) ? 4'h0 : (s > 8) ? 4'h8 : 4'(s));
    end
    check("starts", n_st, 1);
    check("cal strobes", n_cs, 8);
    $display("start and calibration test done");
    // mid-run reset must clear the enable register again
    host.send(ccs_pkg::CMD_SRE_WR, 8'hFF);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("sre after reset", sre, 8'h00);
    check("ready after reset", rdy, 1'b1);
    ask(ccs_pkg::CMD_SELFTEST, 8'h00);
    settle();
    check("replies left", exp_q.size(), 0);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
